// >>> hdl/block_memory_consts.vh
// Constants shared by the dual-port block memory and its lane helper.
// Assumes inclusion by bare name from files under hdl/.
`ifndef BLOCK_MEMORY_CONSTS_VH
`define BLOCK_MEMORY_CONSTS_VH

// Storage geometry: 4096 bits kept as 256 rows of 16 bits
`define MEM_BITS 4096
`define MEM_ROW_W 16
`define MEM_ROWS 256
`define MEM_ROW_AW 8
`define MEM_OFF_W 4
`define MEM_BIT_AW 12

// Port buses
`define PORT_ADDR_W 12
`define PORT_DATA_W 16

// Width select codes: log2 of the port width
`define WSEL_W 3
`define WSEL_X1 3'h0
`define WSEL_X2 3'h1
`define WSEL_X4 3'h2
`define WSEL_X8 3'h3
`define WSEL_X16 3'h4

// Reset values of registered outputs
`define RDATA_RESET 16'h0000
`define FLAG_RESET 1'h0

`endif

// >>> hdl/port_lane.v
// Per-port width lane: maps a port address and width to a storage row,
// a bit mask within that row, aligned write data and extracted read data.
// Purely combinational; the parent owns all state and the array.
`timescale 1ns/1ps
`include "block_memory_consts.vh"

module port_lane
(
  input wire [`WSEL_W-1:0] wsel,
  input wire [`PORT_ADDR_W-1:0] addr,
  input wire [`PORT_DATA_W-1:0] wdata,
  input wire [`MEM_ROW_W-1:0] row_data,
  output wire [`MEM_ROW_AW-1:0] row,
  output wire [`MEM_ROW_W-1:0] mask,
  output wire [`MEM_ROW_W-1:0] wdata_aligned,
  output wire [`PORT_DATA_W-1:0] rdata
);

  // Codes above x16 fold onto x16 so the lane never addresses past a row
  wire [`WSEL_W-1:0] code;
  wire [4:0] width;
  wire [`MEM_BIT_AW-1:0] bit_pos;
  wire [`MEM_OFF_W-1:0] off;
  wire [`PORT_DATA_W-1:0] width_mask;
  wire [`MEM_ROW_W-1:0] shifted_row;

  assign code = (wsel > `WSEL_X16) ? `WSEL_X16 : wsel;
  assign width = 5'h01 << code;

  // Word A of width W starts at storage bit A*W; upper address bits drop out [R4] [R5]
  assign bit_pos = addr << code;
  assign row = bit_pos[`MEM_BIT_AW-1:`MEM_OFF_W];
  assign off = bit_pos[`MEM_OFF_W-1:0];

  // One mask bit per storage bit: set for bits off .. off+W-1 [R5]
  genvar i;
  generate
    for (i = 0; i < `MEM_ROW_W; i = i + 1)
    begin : g_bit
      assign mask[i] = (i >= off) && (i < ({1'b0, off} + width));
      assign width_mask[i] = (i < width);
    end
  endgenerate

  // Write data sits in the low W bits of the port bus [R3]
  assign wdata_aligned = (wdata & width_mask) << off;

  // Read extraction: shift the row down and keep W bits; the rest read zero [R3]
  assign shifted_row = row_data >> off;
  assign rdata = shifted_row & width_mask;

endmodule

// >>> hdl/dual_port_block_memory.v
// Dual-port block memory of 4096 bits with an independent width per port.
// Both ports are driven by user logic on the one clock clk; clk_en freezes
// every flip-flop but the reset synchroniser, including the storage array.
`timescale 1ns/1ps
`include "block_memory_consts.vh"

// Functional notes
// (R1) Exactly 4096 storage bits; every port read and write happens on a clock edge.
// (R2) Two ports, each with its own enable, write, width and address controls.
// (R3) Each port picks its own width; one array written one width, read another.
// (R4) Widths 1,2,4,8,16 with depths 4096,2048,1024,512,256 and 12..8 address bits.
// (R5) Word A of width W holds storage bits A*W through A*W+W-1.
module dual_port_block_memory
(
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  input wire a_en,
  input wire a_we,
  input wire [`WSEL_W-1:0] a_wsel,
  input wire [`PORT_ADDR_W-1:0] a_addr,
  input wire [`PORT_DATA_W-1:0] a_wdata,
  output wire [`PORT_DATA_W-1:0] a_rdata,
  input wire b_en,
  input wire b_we,
  input wire [`WSEL_W-1:0] b_wsel,
  input wire [`PORT_ADDR_W-1:0] b_addr,
  input wire [`PORT_DATA_W-1:0] b_wdata,
  output wire [`PORT_DATA_W-1:0] b_rdata,
  output wire collision
);

  // Reset release synchroniser: asynchronous assert, two-flop release
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // Storage: 256 rows of 16 bits, 4096 bits in all [R1]
  reg [`MEM_ROW_W-1:0] mem [0:`MEM_ROWS-1];

  // Lane results for each port
  wire [`MEM_ROW_AW-1:0] a_row;
  wire [`MEM_ROW_W-1:0] a_mask;
  wire [`MEM_ROW_W-1:0] a_wd;
  wire [`PORT_DATA_W-1:0] a_rd;
  wire [`MEM_ROW_AW-1:0] b_row;
  wire [`MEM_ROW_W-1:0] b_mask;
  wire [`MEM_ROW_W-1:0] b_wd;
  wire [`PORT_DATA_W-1:0] b_rd;
  wire [`MEM_ROW_W-1:0] a_row_data;
  wire [`MEM_ROW_W-1:0] b_row_data;

  assign a_row_data = mem[a_row];
  assign b_row_data = mem[b_row];

  // Port A width lane, its own width code [R3] [R4]
  port_lane u_lane_a
  (
    .wsel(a_wsel),
    .addr(a_addr),
    .wdata(a_wdata),
    .row_data(a_row_data),
    .row(a_row),
    .mask(a_mask),
    .wdata_aligned(a_wd),
    .rdata(a_rd)
  );

  // Port B width lane, independent of port A [R2] [R3] [R4]
  port_lane u_lane_b
  (
    .wsel(b_wsel),
    .addr(b_addr),
    .wdata(b_wdata),
    .row_data(b_row_data),
    .row(b_row),
    .mask(b_mask),
    .wdata_aligned(b_wd),
    .rdata(b_rd)
  );

  // Write qualifiers: a port writes only when enabled, write set and not frozen
  wire a_wr;
  wire b_wr;
  wire same_row;
  wire overlap;

  assign a_wr = clk_en && a_en && a_we;
  assign b_wr = clk_en && b_en && b_we;
  assign same_row = (a_row == b_row);
  assign overlap = a_wr && b_wr && same_row && ((a_mask & b_mask) != 16'h0000);

  // Merged row contents; when both ports hit one row their masks are combined
  // so neither write is lost, and B wins any bit both claim
  reg [`MEM_ROW_W-1:0] a_row_next;
  reg [`MEM_ROW_W-1:0] b_row_next;
  reg [`MEM_ROW_W-1:0] shared_row_next;

  always @*
  begin
    a_row_next = (a_row_data & ~a_mask) | (a_wd & a_mask);
    b_row_next = (b_row_data & ~b_mask) | (b_wd & b_mask);
    shared_row_next = (b_row_data & ~(a_mask | b_mask))
                      | (a_wd & a_mask & ~b_mask)
                      | (b_wd & b_mask);
  end

  // Array update on the clock edge only; the array has no reset [R1] [R5]
  always @(posedge clk)
  begin
    if (a_wr && b_wr && same_row)
    begin
      mem[b_row] <= shared_row_next; // [R2]
    end
    else
    begin
      if (a_wr)
      begin
        mem[a_row] <= a_row_next; // [R1]
      end
      if (b_wr)
      begin
        mem[b_row] <= b_row_next; // [R1]
      end
    end
  end

  // Registered read data per port; a write cycle returns the old contents
  // (read before write), which keeps each port free of the other's timing
  reg [`PORT_DATA_W-1:0] a_rdata_reg;
  reg [`PORT_DATA_W-1:0] a_rdata_next;
  reg [`PORT_DATA_W-1:0] b_rdata_reg;
  reg [`PORT_DATA_W-1:0] b_rdata_next;

  always @*
  begin
    a_rdata_next = a_rdata_reg;
    b_rdata_next = b_rdata_reg;
    if (a_en)
    begin
      a_rdata_next = a_rd; // [R1] [R3]
    end
    if (b_en)
    begin
      b_rdata_next = b_rd; // [R1] [R3]
    end
  end

  // Read registers hold their value while a port is idle or clk_en is low
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_rdata_reg <= `RDATA_RESET;
      b_rdata_reg <= `RDATA_RESET;
    end
    else if (clk_en)
    begin
      a_rdata_reg <= a_rdata_next;
      b_rdata_reg <= b_rdata_next;
    end
  end

  // Collision flag: one cycle high after both ports wrote a common bit,
  // so user logic can spot lost port A data
  reg collision_reg;
  reg collision_next;

  always @*
  begin
    collision_next = overlap;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      collision_reg <= `FLAG_RESET;
    end
    else if (clk_en)
    begin
      collision_reg <= collision_next;
    end
  end

  // Outputs straight from flip-flops
  assign a_rdata = a_rdata_reg;
  assign b_rdata = b_rdata_reg;
  assign collision = collision_reg;

endmodule

// >>> dv/port_driver.sv
// Model of the user logic on one port: one access per call.
// Assumes clk is the memory clock; idle we, addr and wdata are scrambled, en dropped, wsel held.
`timescale 1ns/1ps
module port_driver
(
  input wire clk,
  output reg en = 1'b0,
  output reg we = 1'b0,
  output reg [2:0] wsel = 3'h0,
  output reg [11:0] addr = 12'h000,
  output reg [15:0] wdata = 16'h0000
);
  // Held across one rising edge; en dropped and we, addr, wdata inverted after so stale values never pass
  task op(input w, input [2:0] ws, input [11:0] ad, input [15:0] d);
    begin
      @(negedge clk);
      en <= 1'b1;
      we <= w;
      wsel <= ws;
      addr <= ad;
      wdata <= d;
      @(negedge clk);
      en <= 1'b0;
      we <= ~w;
      addr <= ~ad;
      wdata <= ~d;
    end
  endtask
endmodule

// >>> dv/block_memory_assertions.sv
// Checker on the block memory top ports.
// Assumes one clock and the active-low reset.
`timescale 1ns/1ps
module block_memory_checker
(
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  input wire a_en,
  input wire a_we,
  input wire [2:0] a_wsel,
  input wire [11:0] a_addr,
  input wire [15:0] a_wdata,
  input wire [15:0] a_rdata,
  input wire b_en,
  input wire b_we,
  input wire [2:0] b_wsel,
  input wire [11:0] b_addr,
  input wire [15:0] b_rdata,
  input wire collision
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Wide write, idle cycle, then read of the same word with B quiet
  sequence s_wr;
    clk_en && a_en && a_we && a_wsel == 3'h4 && !b_en;
  endsequence
  sequence s_rd;
    !a_en && !b_en ##1 clk_en && a_en && !a_we && a_wsel == 3'h4 && !b_en
      && a_addr == $past(a_addr, 2);
  endsequence
  property p_wr_rd;
    s_wr ##1 s_rd |=> a_rdata == $past(a_wdata, 3);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("A readback");
  property p_a_hold;
    !(clk_en && a_en) |=> $stable(a_rdata);
  endproperty
  a_a_hold: assert property (p_a_hold) else $error("A hold");
  property p_b_hold;
    !(clk_en && b_en) |=> $stable(b_rdata);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("B hold");
  property p_a_x1;
    clk_en && a_en && a_wsel == 3'h0 |=> a_rdata[15:1] == 15'h0000;
  endproperty
  a_a_x1: assert property (p_a_x1) else $error("A x1");
  property p_b_x8;
    clk_en && b_en && b_wsel == 3'h3 |=> b_rdata[15:8] == 8'h00;
  endproperty
  a_b_x8: assert property (p_b_x8) else $error("B x8");
  // Both ports writing one x16 word must raise the flag on the next cycle
  sequence s_both_wr16;
    clk_en && a_en && a_we && b_en && b_we && a_wsel == 3'h4 && b_wsel == 3'h4
      && a_addr[7:0] == b_addr[7:0];
  endsequence
  property p_coll_set;
    s_both_wr16 |=> collision;
  endproperty
  a_coll_set: assert property (p_coll_set) else $error("collision missed");
  // Without two writes in an enabled cycle the flag drops again
  property p_coll_clr;
    clk_en && !(a_en && a_we && b_en && b_we) |=> !collision;
  endproperty
  a_coll_clr: assert property (p_coll_clr) else $error("collision stuck");
endmodule
bind dual_port_block_memory block_memory_checker chk (.*);

// >>> dv/tb_top.sv
// Random and corner bench for the block memory.
// Assumes port_driver stands for the user logic on each port.
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg clk_en = 1'b1;
  wire a_en, a_we, b_en, b_we, collision;
  wire [2:0] a_wsel, b_wsel;
  wire [11:0] a_addr, b_addr;
  wire [15:0] a_wdata, b_wdata, a_rdata, b_rdata;
  reg ref_mem [0:4095];
  integer miscompares = 0;
  integer checked = 0;
  integer cycles = 0;
  integer seed = 32'ha9a607ff;
  integer i;
  reg [31:0] rnd_a;
  reg [31:0] rnd_b;
  reg [31:0] rnd_w;
  always #50 clk = ~clk;
  dual_port_block_memory uut (.*);
  port_driver drv_a (.clk(clk), .en(a_en), .we(a_we), .wsel(a_wsel), .addr(a_addr),
    .wdata(a_wdata));
  port_driver drv_b (.clk(clk), .en(b_en), .we(b_we), .wsel(b_wsel), .addr(b_addr),
    .wdata(b_wdata));
  // Bits of word ad at width code ws, from the reference array
  function [15:0] expect_rd(input [2:0] ws, input [11:0] ad);
    integer k;
    integer lw;
    begin
      lw = (ws > 4) ? 4 : ws;
      expect_rd = 16'h0000;
      for (k = 0; k < (1 << lw); k = k + 1)
        expect_rd[k] = ref_mem[((ad << lw) + k) & 12'hfff];
    end
  endfunction
  task check(input [15:0] seen, input [15:0] exp, input [8*12-1:0] what);
    begin
      checked = checked + 1;
      if (seen !== exp)
        $display("Error %0s expected %h seen %h", what, exp, seen);
      if (seen !== exp)
        miscompares = miscompares + 1;
    end
  endtask
  // Reference write of word ad at width code ws; codes above x16 act as x16
  task ref_put(input [2:0] ws, input [11:0] ad, input [15:0] d);
    integer k;
    integer lw;
    begin
      lw = (ws > 4) ? 4 : ws;
      for (k = 0; k < (1 << lw); k = k + 1)
        ref_mem[((ad << lw) + k) & 12'hfff] = d[k];
    end
  endtask
  // One access on port pb; writes land in the model only when clocks are enabled
  task access(input pb, input w, input [2:0] ws, input [11:0] ad, input [15:0] d);
    begin
      if (pb)
        drv_b.op(w, ws, ad, d);
      else
        drv_a.op(w, ws, ad, d);
      if (w && clk_en)
        ref_put(ws, ad, d);
      if (!w)
        check(pb ? b_rdata : a_rdata, expect_rd(ws, ad), "rdata");
    end
  endtask
  task wrap_up;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Hang guard, well above the expected run
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    // Array is not reset, so fill it through both ports first
    for (i = 0; i < 256; i = i + 1)
    begin
      rnd_b = $random(seed);
      access(i[0], 1'b1, 3'h4, i[11:0], rnd_b[15:0]);
    end
    $display("fill done");
    access(1'b0, 1'b1, 3'h4, 12'h000, 16'h1234);
    access(1'b0, 1'b0, 3'h4, 12'h000, 16'h0000);
    for (i = 0; i < 4; i = i + 1)
      access(1'b1, 1'b0, 3'h2, i[11:0], 16'h0000);
    for (i = 0; i < 8; i = i + 1)
      access(i[0], 1'b0, i[2:0], 12'hfff, 16'h0000);
    @(negedge clk);
    clk_en = 1'b0;
    access(1'b0, 1'b1, 3'h4, 12'h007, 16'hbeef);
    clk_en = 1'b1;
    access(1'b1, 1'b0, 3'h4, 12'h007, 16'h0000);
    // Both ports write one word together: flag rises and B owns every bit
    fork
      drv_a.op(1'b1, 3'h4, 12'h021, 16'h1111);
      drv_b.op(1'b1, 3'h4, 12'h021, 16'h2222);
    join
    check({15'h0000, collision}, 16'h0001, "collision");
    ref_put(3'h4, 12'h021, 16'h1111);
    ref_put(3'h4, 12'h021, 16'h2222);
    // Disjoint bytes of one row from both ports: both kept, no flag
    fork
      drv_a.op(1'b1, 3'h3, 12'h044, 16'h00ab);
      drv_b.op(1'b1, 3'h3, 12'h045, 16'h00cd);
    join
    check({15'h0000, collision}, 16'h0000, "collision");
    ref_put(3'h3, 12'h044, 16'h00ab);
    ref_put(3'h3, 12'h045, 16'h00cd);
    access(1'b0, 1'b0, 3'h4, 12'h021, 16'h0000);
    access(1'b1, 1'b0, 3'h4, 12'h022, 16'h0000);
    $display("corners done");
    repeat (2000)
    begin
      rnd_a = $random(seed);
      rnd_b = $random(seed);
      rnd_w = {$random(seed)} % 5;
      access(rnd_a[0], rnd_a[1], rnd_w[2:0], rnd_a[27:16], rnd_b[15:0]);
    end
    $display("random done");
    wrap_up;
  end
endmodule
